//--- pkg/link_tx_pkg.sv
// Constants and types for the interprocessor link transmitter
// Notes on behaviour
// - Write port A loads accumulator bits 1-15 into the address counter, then F.
// - Write port B loads the whole accumulator into the word counter, then F.
// - Write port C takes accumulator bits 0-3 as target receiver code, then F.
// - Status: target code 0-3, own code 4-7, flags in bits 12-15.
// - Own identity is a 4-bit jumper code, default all ones.
// - Read port A returns address counter on bits 1-15, bit 0 zero.
// - Read port B returns the word counter, then F.
// - Start clears Done, sets Busy, clears timeout and local completion.
// - Clear (F=10) clears Busy, Done, timeout and local completion.
// - While Busy, fetch word at address counter and send to selected receiver.
// - Refused word sets lock-out; keep retrying; timeout only after 10 ms.
// - Acceptance clears lock-out; both counters increment per transfer.
// - Local overflow sets bit 14, remote completion bit 15, stall sets timeout.
// - Any end flag clears Busy, sets Done, interrupts unless disabled.
// - Remote completion never sets timeout; only a 10 ms stall does.
// - Answer only device code 6; bits 8-9 carry the control function.
// - Interrupt disable loads from mask bit 12 on every mask-out.
package link_tx_pkg;
   localparam logic [5:0] device_code = 6'h06;
   localparam logic [1:0] func_none = 2'h0;
   localparam logic [1:0] func_start = 2'h1;
   localparam logic [1:0] func_clear = 2'h2;
   localparam logic [1:0] func_pulse = 2'h3;
   localparam logic [3:0] own_code_default = 4'hf;
   localparam int mask_disable_bit = 12;
   localparam int clock_mhz = 40;
   localparam int timeout_ms = 10;
   localparam int timeout_cycles = timeout_ms * 1000 * clock_mhz;
   localparam logic [14:0] address_reset = 15'h0000;
   localparam logic [15:0] count_reset = 16'h0000;
   localparam logic [3:0] target_reset = 4'h0;
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_fetch = 2'b01,
      st_send = 2'b11
   } tx_state_t;
endpackage

//--- hdl/tx_word_buffer.sv
// Two-entry valid/ready buffer between the data channel and the link
`timescale 1ns/10ps
`default_nettype none
module tx_word_buffer #(
   parameter int width = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   input wire logic flush,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [width-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [width-1:0] out_data
);
   initial begin
      if (width < 1) $error("width must be positive");
   end
   typedef struct packed {
      logic [1:0][width-1:0] word;
      logic [1:0] count;
   } buf_state_t;
   buf_state_t state, next_state;
   logic push, pop;
   assign in_ready = state.count != 2'h2;
   assign out_valid = state.count != 2'h0;
   assign out_data = state.word[0];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_comb begin
      next_state = state;
      if (pop) begin
         next_state.word[0] = state.word[1];
      end
      if (push) begin
         if (state.count == 2'h0 || (state.count == 2'h1 && pop)) begin
            next_state.word[0] = in_data;
         end else begin
            next_state.word[1] = in_data;
         end
      end
      next_state.count = state.count + {1'b0, push} - {1'b0, pop};
      // Clear drops held words: a stopped transfer loses them
      if (flush) begin
         next_state.count = 2'h0;
      end
   end
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
endmodule
`default_nettype wire

//--- hdl/tx_stall_timer.sv
// Acceptance stall timer for the link transmitter
`timescale 1ns/10ps
`default_nettype none
module tx_stall_timer #(
   parameter int limit = 400000
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Control
   input wire logic run,
   input wire logic restart,
   output logic expired
);
   localparam int cw = $clog2(limit + 1);
   initial begin
      if (limit < 1) $error("limit must be positive");
   end
   typedef struct packed {
      logic [cw-1:0] count;
   } timer_state_t;
   timer_state_t state, next_state;
   assign expired = state.count == cw'(limit);
   always_comb begin
      next_state = state;
      if (!run || restart) begin
         next_state.count = '0;
      end else if (!expired) begin
         next_state.count = state.count + cw'(1);
      end
   end
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
endmodule
`default_nettype wire

//--- hdl/link_tx_unit.sv
// Transmitter of the interprocessor adapter: in-out bus, data channel and link
`timescale 1ns/10ps
`default_nettype none
module link_tx_unit #(
   parameter int timeout_limit = link_tx_pkg::timeout_cycles
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Jumpers
   input wire logic [3:0] own_code_jumpers,
   // In-out bus: selection, strobes, function
   input wire logic [5:0] device_select,
   input wire logic [1:0] control_function,
   input wire logic write_port_a,
   input wire logic write_port_b,
   input wire logic write_port_c,
   input wire logic read_port_a,
   input wire logic read_port_b,
   input wire logic read_port_c,
   input wire logic mask_out,
   input wire logic [15:0] bus_data_in,
   output logic [15:0] bus_data_out,
   output logic bus_data_oe,
   // In-out bus: flags and interrupt
   output logic selected_busy,
   output logic selected_done,
   output logic interrupt_request,
   // Data channel
   output logic channel_request,
   input wire logic channel_grant,
   output logic [14:0] channel_address,
   input wire logic channel_data_valid,
   input wire logic [15:0] channel_data,
   // Link to the remote receiver
   output logic link_valid,
   output logic [3:0] link_target,
   output logic [3:0] link_source,
   output logic [15:0] link_word,
   input wire logic link_accept,
   input wire logic link_locked_out,
   input wire logic link_remote_complete
);
   initial begin
      if (timeout_limit < 1) $error("timeout_limit must be positive");
   end

   typedef struct packed {
      link_tx_pkg::tx_state_t phase;
      logic [14:0] tx_memory_address_counter;
      logic [15:0] tx_word_counter;
      logic [3:0] target_receiver_select;
      logic [3:0] own_code;
      logic busy;
      logic done;
      logic interrupt_disable;
      logic timeout_flag;
      logic lockout_flag;
      logic local_block_complete;
      logic remote_block_complete;
      logic [15:0] read_word;
      logic read_drive;
      logic reset_seen;
   } tx_core_t;

   tx_core_t state, next_state;
   logic selected;
   logic buf_in_ready, buf_out_valid, buf_out_ready, buf_flush;
   logic [15:0] buf_out_data;
   logic stall_expired, accepted, fetch_taken;
   logic [15:0] tx_link_status;

   assign selected = device_select == link_tx_pkg::device_code;
   assign accepted = buf_out_valid && link_accept && state.busy;
   assign buf_out_ready = accepted;
   // A word counts only when it is granted against an open request
   assign fetch_taken = channel_grant && channel_data_valid && channel_request;
   // Start and Clear both empty the buffer, so a word left by a stopped block is never sent
   assign buf_flush = selected && (control_function == link_tx_pkg::func_start
      || control_function == link_tx_pkg::func_clear);

   tx_word_buffer #(
      .width(16)
   ) word_buffer (
      .clock(clock),
      .reset_n(reset_n),
      .flush(buf_flush),
      .in_valid(fetch_taken),
      .in_ready(buf_in_ready),
      .in_data(channel_data),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   tx_stall_timer #(
      .limit(timeout_limit)
   ) stall_timer (
      .clock(clock),
      .reset_n(reset_n),
      .run(state.busy),
      .restart(accepted),
      .expired(stall_expired)
   );

   // Status word layout
   always_comb begin
      tx_link_status = 16'h0000;
      tx_link_status[15:12] = state.target_receiver_select;
      tx_link_status[11:8] = state.own_code;
      tx_link_status[3] = state.timeout_flag;
      tx_link_status[2] = state.lockout_flag;
      tx_link_status[1] = state.local_block_complete;
      tx_link_status[0] = state.remote_block_complete;
   end

   // Bus bit 0 is the most significant bit of every word here
   assign bus_data_out = state.read_word;
   assign bus_data_oe = state.read_drive;
   assign selected_busy = selected && state.busy;
   assign selected_done = selected && state.done;
   assign interrupt_request = state.done && !state.interrupt_disable;
   // Request only while there is room, so the channel stalls with the link
   assign channel_request = state.phase == link_tx_pkg::st_fetch && buf_in_ready;
   assign channel_address = state.tx_memory_address_counter;
   assign link_valid = buf_out_valid && state.busy;
   assign link_target = state.target_receiver_select;
   assign link_source = state.own_code;
   assign link_word = buf_out_data;

   always_comb begin
      logic finish;
      logic [15:0] wc_next;
      finish = 1'b0;
      wc_next = 16'h0000;
      next_state = state;
      next_state.read_drive = 1'b0;
      // Jumpers are caught once, after reset is released
      if (!state.reset_seen) begin
         next_state.own_code = own_code_jumpers;
         next_state.reset_seen = 1'b1;
      end
      if (mask_out) begin
         next_state.interrupt_disable = bus_data_in[15 - link_tx_pkg::mask_disable_bit];
      end
      // Transfer engine
      if (state.busy) begin
         case (state.phase)
            link_tx_pkg::st_idle: begin
               next_state.phase = link_tx_pkg::st_fetch;
            end
            link_tx_pkg::st_fetch: begin
               if (fetch_taken) begin
                  next_state.phase = link_tx_pkg::st_send;
               end
            end
            link_tx_pkg::st_send: begin
               if (accepted) begin
                  next_state.phase = link_tx_pkg::st_fetch;
               end
            end
            default: begin
               next_state.phase = link_tx_pkg::st_idle;
            end
         endcase
         if (buf_out_valid && link_locked_out && !link_accept) begin
            next_state.lockout_flag = 1'b1;
         end
         if (accepted) begin
            next_state.lockout_flag = 1'b0;
            next_state.tx_memory_address_counter =
               state.tx_memory_address_counter + 15'h0001;
            wc_next = state.tx_word_counter + 16'h0001;
            next_state.tx_word_counter = wc_next;
            if (wc_next == 16'h0000) begin
               next_state.local_block_complete = 1'b1;
               finish = 1'b1;
            end
            if (link_remote_complete) begin
               next_state.remote_block_complete = 1'b1;
               finish = 1'b1;
            end
         end
         // Only a stall, never a normal end, raises timeout
         if (stall_expired && !accepted) begin
            next_state.timeout_flag = 1'b1;
            finish = 1'b1;
         end
         if (finish) begin
            next_state.busy = 1'b0;
            next_state.done = 1'b1;
            next_state.phase = link_tx_pkg::st_idle;
         end
      end else begin
         next_state.phase = link_tx_pkg::st_idle;
      end
      // Programmed transfers, then the control function
      if (selected) begin
         if (write_port_a) begin
            next_state.tx_memory_address_counter = bus_data_in[14:0];
         end
         if (write_port_b) begin
            next_state.tx_word_counter = bus_data_in;
         end
         if (write_port_c) begin
            next_state.target_receiver_select = bus_data_in[15:12];
         end
         if (read_port_a) begin
            next_state.read_word = {1'b0, state.tx_memory_address_counter};
            next_state.read_drive = 1'b1;
         end else if (read_port_b) begin
            next_state.read_word = state.tx_word_counter;
            next_state.read_drive = 1'b1;
         end else if (read_port_c) begin
            next_state.read_word = tx_link_status;
            next_state.read_drive = 1'b1;
         end
         case (control_function)
            link_tx_pkg::func_start: begin
               next_state.done = 1'b0;
               next_state.busy = 1'b1;
               next_state.timeout_flag = 1'b0;
               next_state.local_block_complete = 1'b0;
               next_state.remote_block_complete = 1'b0;
               next_state.lockout_flag = 1'b0;
               next_state.phase = link_tx_pkg::st_idle;
            end
            link_tx_pkg::func_clear: begin
               next_state.busy = 1'b0;
               next_state.done = 1'b0;
               next_state.timeout_flag = 1'b0;
               next_state.local_block_complete = 1'b0;
               next_state.phase = link_tx_pkg::st_idle;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state <= '0;
         state.phase <= link_tx_pkg::st_idle;
         state.tx_memory_address_counter <= link_tx_pkg::address_reset;
         state.tx_word_counter <= link_tx_pkg::count_reset;
         state.target_receiver_select <= link_tx_pkg::target_reset;
         state.own_code <= link_tx_pkg::own_code_default;
      end else begin
         state <= next_state;
      end
   end
endmodule
`default_nettype wire

//--- bench/link_tx_chk.sv
// Port checker for the link transmitter, bound at the foot
`timescale 1ns/10ps
`default_nettype none
module link_tx_chk #(
   parameter int timeout_limit = 50
) (
   // Clock and bus side
   input wire logic clock, reset_n,
   input wire logic [5:0] device_select,
   input wire logic [1:0] control_function,
   input wire logic read_port_a, read_port_b, read_port_c,
   input wire logic [15:0] bus_data_out,
   input wire logic bus_data_oe, selected_busy, selected_done, interrupt_request,
   // Channel and link side
   input wire logic channel_request, channel_data_valid, link_valid, link_accept,
   input wire logic [3:0] link_target,
   input wire logic [15:0] link_word
);
   wire logic sel = device_select == link_tx_pkg::device_code;
   wire logic rd = sel && (read_port_a || read_port_b || read_port_c);
   wire logic fstart = sel && control_function == link_tx_pkg::func_start;
   wire logic fclear = sel && control_function == link_tx_pkg::func_clear;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   int stall = 0;
   // Busy cycles since the last accepted word, to bound the stall timer
   always_ff @(posedge clock) begin
      if (!reset_n || !selected_busy || link_accept) begin
         stall <= 0;
      end else begin
         stall <= stall + 1;
      end
   end
   property p_stall_bound; stall <= timeout_limit + 2; endproperty
   a_stall_bound: assert property (p_stall_bound) else $error("stall outlived the timer");
   property p_idle_quiet; sel && !selected_busy |-> !link_valid && !channel_request; endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("link active while idle");
   property p_read_oe; rd |=> bus_data_oe; endproperty
   a_read_oe: assert property (p_read_oe) else $error("read got no answer");
   property p_read_a; sel && read_port_a |=> bus_data_out[15] == 1'b0; endproperty
   a_read_a: assert property (p_read_a) else $error("address read bit 0 set");
   property p_status; sel && read_port_c |=> bus_data_out[7:4] == 4'h0; endproperty
   a_status: assert property (p_status) else $error("status spare bits set");
   property p_start;
      fstart |=> !selected_done && (selected_busy || !sel);
   endproperty
   a_start: assert property (p_start) else $error("start did not arm");
   property p_clear;
      fclear |=> !selected_busy && !selected_done && !interrupt_request;
   endproperty
   a_clear: assert property (p_clear) else $error("clear left a flag");
   property p_int; interrupt_request |-> !selected_busy && (selected_done || !sel); endproperty
   a_int: assert property (p_int) else $error("interrupt without done");
   // A refused word must be offered again unchanged, or the receiver sees a torn word
   property p_link_hold;
      link_valid && !link_accept && selected_busy |=>
         !selected_busy || (link_valid && $stable(link_word) && $stable(link_target));
   endproperty
   a_link_hold: assert property (p_link_hold) else $error("offered word dropped");
   property p_chan_hold;
      channel_request && !channel_data_valid && selected_busy |=>
         channel_request || !selected_busy;
   endproperty
   a_chan_hold: assert property (p_chan_hold) else $error("fetch request dropped");
   c_accept: cover property (link_valid && link_accept);
   c_int: cover property (interrupt_request);
   c_read: cover property (rd ##1 bus_data_oe);
endmodule
bind link_tx_unit link_tx_chk #(.timeout_limit(timeout_limit)) chk (.*);
`default_nettype wire

//--- bench/link_rx_model.sv
// Behavioural receiver at the far end of the link
`timescale 1ns/10ps
`default_nettype none
module link_rx_model (
   // Clock and test controls
   input wire logic clock, reset_n, lock_other, load,
   input wire logic [3:0] rx_code, delay,
   input wire logic [15:0] rx_count,
   // Link
   input wire logic link_valid,
   input wire logic [3:0] link_target,
   output logic link_accept,
   output logic link_locked_out,
   output logic link_remote_complete
);
   logic [3:0] waited;
   logic [15:0] left;
   wire logic mine = link_valid && link_target == rx_code;
   // Refusal only shows while a word is offered to this receiver
   assign link_locked_out = mine && lock_other;
   assign link_remote_complete = link_accept && left == 16'h0001;
   always_ff @(posedge clock) begin
      if (!reset_n || !mine || link_accept || lock_other) begin
         link_accept <= 1'b0;
         waited <= 4'h0;
      end else if (waited >= delay) begin
         link_accept <= 1'b1;
      end else begin
         waited <= waited + 4'h1;
      end
      // A count of zero never completes, like an open-ended reception
      if (load) begin
         left <= rx_count;
      end else if (link_accept && left != 16'h0000) begin
         left <= left - 16'h0001;
      end
   end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the link transmitter
`timescale 1ns/10ps
`default_nettype none
`define CHECK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
   logic clock = 1'b0, reset_n = 1'b0, channel_data_valid = 1'b0, v, dis = 1'b0;
   logic lock_other = 1'b0, load = 1'b0;
   logic [3:0] own_code_jumpers = 4'hf, rx_code = 4'h0, delay = 4'h0, link_target, link_source;
   logic [5:0] device_select = 6'h06;
   logic [1:0] control_function = 2'h0;
   logic [6:0] stb = 7'h00;
   logic [15:0] bus_data_in = 16'h0000, channel_data = 16'h0000, rx_count = 16'h0000;
   logic [15:0] bus_data_out, link_word, rdata;
   logic [14:0] channel_address, exp_addr = 15'h0000;
   logic bus_data_oe, selected_busy, selected_done, interrupt_request, channel_request;
   logic link_valid, link_accept, link_locked_out, link_remote_complete;
   wire logic write_port_a, write_port_b, write_port_c, read_port_a, read_port_b;
   wire logic read_port_c, mask_out;
   wire logic channel_grant = channel_data_valid;
   int bad_count = 0, checked = 0, cycles = 0, words = 0, k;
   assign {mask_out, read_port_c, read_port_b, read_port_a, write_port_c, write_port_b,
      write_port_a} = stb;
   link_tx_unit #(.timeout_limit(50)) DUT (.*);
   link_rx_model rx (.*);
   always #12.5 clock = ~clock;
   function automatic logic [15:0] mem_word(input logic [14:0] a);
      return {a, 1'b1} ^ 16'h5a3c;
   endfunction
   function automatic logic [3:0] flags(input int rem, lkc, hit);
      if (!hit) return 4'h8;
      if (lkc > 60) return 4'hc;
      return (rem != 0) ? 4'h1 : 4'h2;
   endfunction
   // Memory side: grants come at random, and an idle data bus never holds the old word
   always @(negedge clock) begin
      v = channel_request && !channel_data_valid && ($urandom % 3 != 0);
      channel_data_valid <= v;
      channel_data <= v ? mem_word(channel_address) : ~channel_data;
   end
   always @(posedge clock) begin
      cycles++;
      if (link_valid && link_accept) begin
         `CHECK(link_word, mem_word(exp_addr))
         `CHECK({link_target, link_source}, {rx_code, own_code_jumpers})
         exp_addr++;
         words++;
      end
      if (cycles == 20000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic io(input logic [6:0] s, input logic [1:0] f, input logic [15:0] d);
      stb = s;
      control_function = f;
      bus_data_in = d;
      @(negedge clock);
      rdata = bus_data_out;
      stb = 7'h00;
      control_function = 2'h0;
      bus_data_in = ~d;
      // An idle cycle keeps back-to-back calls from setting a strobe twice in one step
      @(negedge clock);
   endtask
   task automatic block(input int n, rem, lkc, hit);
      logic [14:0] a;
      logic [3:0] t, f;
      int i, w;
      a = 15'($urandom);
      t = 4'($urandom);
      f = flags(rem, lkc, hit);
      w = f[3] ? 0 : (rem != 0 ? rem : n);
      rx_code = hit ? t : t + 4'h1;
      rx_count = 16'(rem);
      delay = 4'($urandom % 4);
      lock_other = lkc > 0;
      dis = 1'($urandom);
      load = 1'b1;
      io(7'h40, 2'h2, {12'h000, dis, 3'h0});
      load = 1'b0;
      exp_addr = a;
      words = 0;
      io(7'h01, 2'h0, {1'b0, a});
      io(7'h02, 2'h0, 16'(-n));
      io(7'h04, 2'h1, {t, 12'($urandom)});
      for (i = 0; i < 3000 && selected_done !== 1'b1; i++) begin
         if (i == lkc) lock_other = 1'b0;
         @(negedge clock);
      end
      lock_other = 1'b0;
      `CHECK(selected_done, 1'b1)
      `CHECK(interrupt_request, !dis)
      io(7'h20, 2'h0, 16'h0000);
      `CHECK(rdata, {t, own_code_jumpers, 4'h0, f})
      io(7'h08, 2'h0, 16'h0000);
      `CHECK(rdata, {1'b0, a + 15'(w)})
      io(7'h10, 2'h0, 16'h0000);
      `CHECK(rdata, 16'(w - n))
      `CHECK(words, w)
      $display("block of %0d ended with flags %h", n, f);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      k = $urandom(32'ha87b);
      own_code_jumpers = 4'($urandom);
      repeat (4) @(negedge clock);
      reset_n = 1'b1;
      repeat (2) @(negedge clock);
      io(7'h08, 2'h0, 16'h0000);
      `CHECK(rdata, 16'h0000)
      io(7'h20, 2'h0, 16'h0000);
      `CHECK(rdata, {4'h0, own_code_jumpers, 8'h00})
      device_select = 6'h07;
      io(7'h01, 2'h1, 16'h7fff);
      device_select = 6'h06;
      `CHECK(selected_busy, 1'b0)
      io(7'h08, 2'h0, 16'h0000);
      `CHECK(rdata, 16'h0000)
      $display("reset and refusal test ended");
      block(1, 0, 0, 1);
      for (k = 0; k < 5; k++) block(2 + $urandom % 6, 0, 0, 1);
      block(5, 2, 0, 1);
      block(4, 0, 20, 1);
      block(3, 0, 200, 1);
      block(3, 0, 0, 0);
      rx_code = 4'h9;
      delay = 4'hf;
      io(7'h04, 2'h1, 16'h9000);
      repeat (10) @(negedge clock);
      io(7'h00, 2'h2, 16'h0000);
      `CHECK({selected_busy, selected_done, interrupt_request}, 3'b000)
      io(7'h20, 2'h0, 16'h0000);
      `CHECK({rdata[3], rdata[1]}, 2'b00)
      $display("clear test ended");
      finish_test();
   end
endmodule
`default_nettype wire
